// ===== sbcd_pkg.sv
package sbcd_pkg;

    localparam logic [3:0] SBCD_CMD_READ     = 4'h0;
    localparam logic [3:0] SBCD_CMD_WRITE    = 4'h8;
    localparam logic [3:0] SBCD_CMD_PERIODIC = 4'hb;
    localparam logic [3:0] SBCD_GLOBAL_ADDR  = 4'h0;
    localparam logic [7:0] SBCD_PHYS_ADDR_RA = 8'h11;
    localparam logic [3:0] SBCD_PHYS_RST     = 4'h0;
    localparam logic [7:0] SBCD_CRC_POLY     = 8'h2f;
    localparam logic [7:0] SBCD_CRC_SEED     = 8'hff;
    localparam int         SBCD_CRC_STEPS    = 40;
    localparam int         SBCD_MSG_BITS     = 32;

    typedef struct packed {
        logic [3:0] frame_dev_addr_field;
        logic [3:0] cmd;
        logic [7:0] hi;
        logic [7:0] lo;
    } sbcd_frame_s;

endpackage

// ===== sbcd_crc.sv
`timescale 1ns/1ps
module sbcd_crc
    import sbcd_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    input  wire logic        start_i,
    input  wire logic [31:0] msg_i,
    output logic             busy_o,
    output logic             done_o,
    output logic [7:0]       crc_o
);
    logic [31:0] sh_r;
    logic [7:0]  crc_r;
    logic [5:0]  cnt_r;
    logic        fb;

    // message then eight zeros rotate into the lsb end, msb first
    assign fb     = crc_r[7];
    assign busy_o = (cnt_r != 6'h00);
    assign crc_o  = crc_r;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sh_r   <= 32'h0000_0000;
            crc_r  <= 8'h00;
            cnt_r  <= 6'h00;
            done_o <= 1'b0;
        end else if (ce_i) begin
            done_o <= (cnt_r == 6'h01);
            if (start_i && !busy_o) begin
                sh_r  <= msg_i;
                crc_r <= SBCD_CRC_SEED;
                cnt_r <= 6'(SBCD_CRC_STEPS);
            end else if (busy_o) begin
                sh_r  <= {sh_r[30:0], 1'b0};
                crc_r <= {crc_r[6:0], sh_r[31]} ^ (fb ? SBCD_CRC_POLY : 8'h00);
                cnt_r <= cnt_r - 6'h01;
            end
        end
    end
endmodule // sbcd_crc

// ===== sbcd_decoder.sv
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
module sbcd_decoder
    import sbcd_pkg::*;
#(
    parameter int NREGS = 256
) (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    input  wire logic        cmd_valid_i,
    input  sbcd_frame_s      cmd_frame_i,
    input  wire logic [NREGS-1:0] readable_i,
    input  wire logic [NREGS-1:0] writable_i,
    output logic             cmd_ready_o,
    output logic             resp_valid_o,
    output sbcd_frame_s      resp_frame_o,
    output logic [7:0]       resp_crc_o,
    output logic [3:0]       phys_addr_reg_o,
    output logic             periodic_mode_enable_o,
    output logic             periodic_collection_mode_o
);
    typedef enum logic [1:0] {IDLE, CALC} sbcd_state_e;

    sbcd_state_e state_r;
    logic [7:0]  regs_r [NREGS];
    logic [3:0]  phys_addr_reg;
    logic        periodic_r;
    sbcd_frame_s resp_r;
    logic        take, addr_ok, glob_prog, is_rd, is_wr, is_pd;
    logic        do_wr, do_rd, resp_go;
    logic        crc_busy, crc_done, crc_start;
    logic [7:0]  crc_val, ra, ra1, rdv, rdv1, wval;

    //////////////////////////////////////////////////////////////////////////
    assign phys_addr_reg = regs_r[SBCD_PHYS_ADDR_RA][3:0];
    assign take      = cmd_valid_i && cmd_ready_o;
    assign ra        = cmd_frame_i.hi;
    assign ra1       = ra + 8'h01;
    // global address never matches; it only reaches programming and periodic entry
    assign addr_ok   = (cmd_frame_i.frame_dev_addr_field == phys_addr_reg)
                       && (cmd_frame_i.frame_dev_addr_field != SBCD_GLOBAL_ADDR);
    assign glob_prog = (cmd_frame_i.frame_dev_addr_field == SBCD_GLOBAL_ADDR)
                       && (ra == SBCD_PHYS_ADDR_RA)
                       && (phys_addr_reg == SBCD_GLOBAL_ADDR);
    assign is_rd     = (cmd_frame_i.cmd == SBCD_CMD_READ);
    assign is_wr     = (cmd_frame_i.cmd == SBCD_CMD_WRITE);
    assign is_pd     = (cmd_frame_i.cmd == SBCD_CMD_PERIODIC);
    assign do_rd     = take && is_rd && addr_ok;
    assign do_wr     = take && is_wr && (addr_ok || glob_prog);
    // other codes fall through with no action
    assign resp_go   = do_rd || do_wr || (take && is_pd && addr_ok);
    assign wval      = writable_i[ra] ? cmd_frame_i.lo : regs_r[ra];
    assign rdv       = readable_i[ra]  ? regs_r[ra]  : 8'h00;
    assign rdv1      = readable_i[ra1] ? regs_r[ra1] : 8'h00;
    // a command is consumed only on an enabled edge
    assign cmd_ready_o = (state_r == IDLE) && ce_i;
    // one start pulse per response, so a finished checksum is never reloaded
    assign crc_start   = (state_r == CALC) && !crc_busy && !crc_done;

    //////////////////////////////////////////////////////////////////////////
    // register array; physical address lives at its own byte address
    genvar g;
    for (g = 0; g < NREGS; g++) begin : g_reg
        always_ff @(posedge clk_i) begin
            if (!rst_n_i) begin
                regs_r[g] <= 8'h00;
            end else if (ce_i && do_wr && writable_i[g] && (ra == 8'(g))) begin
                regs_r[g] <= cmd_frame_i.lo;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            periodic_r <= 1'b0;
        end else if (ce_i && take && is_pd
                     && (addr_ok || cmd_frame_i.frame_dev_addr_field == SBCD_GLOBAL_ADDR)) begin
            periodic_r <= 1'b1;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            resp_r <= '0;
        end else if (ce_i && resp_go) begin
            resp_r.cmd <= cmd_frame_i.cmd;
            resp_r.frame_dev_addr_field <= (do_wr && ra == SBCD_PHYS_ADDR_RA
                                            && writable_i[ra])
                                           ? cmd_frame_i.lo[3:0] : phys_addr_reg;
            if (do_rd) begin
                resp_r.hi <= readable_i[ra] ? rdv1 : 8'h00;
                resp_r.lo <= rdv;
            end else if (do_wr) begin
                resp_r.hi <= writable_i[ra] ? rdv1 : 8'h00;
                resp_r.lo <= writable_i[ra] ? wval : 8'h00;
            end else begin
                resp_r.hi <= 8'h00;
                resp_r.lo <= 8'h00;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_r <= IDLE;
        end else if (ce_i) begin
            unique case (state_r)
                IDLE: if (resp_go) state_r <= CALC;
                CALC: if (crc_done) state_r <= IDLE;
                default: state_r <= IDLE;
            endcase
        end
    end

    sbcd_crc u_crc (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .ce_i    (ce_i),
        .start_i (crc_start),
        .msg_i   ({8'h00, resp_r}),
        .busy_o  (crc_busy),
        .done_o  (crc_done),
        .crc_o   (crc_val)
    );

    assign resp_valid_o = crc_done && ce_i;
    assign resp_frame_o = resp_r;
    assign resp_crc_o   = crc_val;
    assign phys_addr_reg_o = phys_addr_reg;
    assign periodic_mode_enable_o = periodic_r;
    assign periodic_collection_mode_o = periodic_r;

    //////////////////////////////////////////////////////////////////////////
    a_read_mismatch: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (take && is_rd && !addr_ok) |=> state_r == IDLE)
        else $error("mismatched read started a response");
    a_unimpl_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && take && !is_rd && !is_wr && !is_pd) |=> state_r == IDLE)
        else $error("unimplemented command started a response");
    a_read_resp: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && do_rd) |=> (state_r == CALC && resp_r.cmd == SBCD_CMD_READ))
        else $error("matching read gave no response");
    a_read_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && do_rd && !readable_i[ra]) |=> resp_r.hi == 8'h00 && resp_r.lo == 8'h00)
        else $error("unreadable read data not zero");
    a_write_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && do_wr && !writable_i[ra]) |=> resp_r.hi == 8'h00 && resp_r.lo == 8'h00)
        else $error("unwritable write data not zero");
    a_write_store: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && do_wr && writable_i[ra]) |=> resp_r.lo == $past(cmd_frame_i.lo))
        else $error("write response not showing stored byte");
    a_periodic_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && take && is_pd && addr_ok) |=> periodic_r)
        else $error("periodic enable not set");
    a_crc_time: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && state_r == CALC && !crc_busy && !crc_done) |=> crc_busy)
        else $error("crc did not start");
    a_global_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && take && is_rd && cmd_frame_i.frame_dev_addr_field == SBCD_GLOBAL_ADDR)
        |=> state_r == IDLE)
        else $error("global read started a response");
    a_write_ignore: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && take && is_wr && !addr_ok && !glob_prog)
        |=> state_r == IDLE && phys_addr_reg == $past(phys_addr_reg))
        else $error("mismatched write was not ignored");
    a_glob_prog: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && do_wr && glob_prog && writable_i[SBCD_PHYS_ADDR_RA])
        |=> state_r == CALC && phys_addr_reg == $past(cmd_frame_i.lo[3:0]))
        else $error("global address programming not applied");
    a_global_pd: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && take && is_pd && cmd_frame_i.frame_dev_addr_field == SBCD_GLOBAL_ADDR)
        |=> periodic_r && state_r == IDLE)
        else $error("global periodic entry misbehaved");
    a_read_data: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && do_rd && readable_i[ra])
        |=> resp_r.lo == $past(regs_r[ra])
            && resp_r.frame_dev_addr_field == $past(phys_addr_reg))
        else $error("read response data or address wrong");
    a_resp_cmd: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && resp_go) |=> resp_r.cmd == $past(cmd_frame_i.cmd))
        else $error("response command not echoed");
    a_resp_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && !resp_go) |=> $stable(resp_r))
        else $error("response frame changed without a command");
    a_unimpl_keep: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && take && !is_rd && !is_wr && !is_pd)
        |=> periodic_r == $past(periodic_r) && phys_addr_reg == $past(phys_addr_reg))
        else $error("unimplemented command changed state");
    a_resp_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        resp_valid_o |=> !resp_valid_o)
        else $error("response valid longer than one cycle");
    a_crc_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && state_r == IDLE) |=> $stable(crc_val))
        else $error("checksum changed while idle");
    a_ce_freeze: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !ce_i |=> $stable(state_r) && $stable(resp_r) && $stable(periodic_r))
        else $error("state moved while clock enable low");
    c_read: cover property (@(posedge clk_i) do_rd);
    c_write: cover property (@(posedge clk_i) do_wr);
    c_glob: cover property (@(posedge clk_i) do_wr && glob_prog);
    c_resp: cover property (@(posedge clk_i) resp_valid_o);
    c_periodic: cover property (@(posedge clk_i) ce_i && take && is_pd);
endmodule // sbcd_decoder

// ===== sbcd_master_model.sv
`timescale 1ns/1ps
module sbcd_master_model
    import sbcd_pkg::*;
(
    input  wire logic  clk_i,
    input  wire logic  cmd_ready_i,
    output logic       cmd_valid_o,
    output sbcd_frame_s cmd_frame_o
);
    initial begin
        cmd_valid_o = 1'b0;
        cmd_frame_o = '0;
    end
    // frame held until the take edge; a released bus shows the inverse
    task automatic send(input sbcd_frame_s f, output logic took);
        took = 1'b0;
        @(negedge clk_i);
        cmd_valid_o = 1'b1;
        cmd_frame_o = f;
        for (int k = 0; k < 100 && !took; k++) begin
            @(posedge clk_i);
            took = cmd_ready_i === 1'b1;
        end
        @(negedge clk_i);
        cmd_valid_o = 1'b0;
        cmd_frame_o = ~f;
    endtask
endmodule // sbcd_master_model

// ===== tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin failures++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module tb;
    import sbcd_pkg::*;
    logic         clk_i, rst_n_i, cmd_valid_i, cmd_ready_o, resp_valid_o, pm_en, pm_mode, took;
    logic         ce;
    sbcd_frame_s  cmd_frame_i, resp_frame_o;
    logic [7:0]   resp_crc_o;
    logic [3:0]   phys_o, phys;
    logic [255:0] rd_map, wr_map;
    logic [7:0]   m [256];
    int           failures, n_compared;
    // {response expected, frame}
    localparam logic [24:0] ROWS [11] = '{
        {1'b0, 24'h00_2000}, {1'b1, 24'h08_1105}, {1'b0, 24'h08_1107}, {1'b0, 24'h38_20ff},
        {1'b1, 24'h58_20a5}, {1'b1, 24'h58_213c}, {1'b1, 24'h50_2000}, {1'b0, 24'h30_2000},
        {1'b1, 24'h50_3000}, {1'b1, 24'h58_9077}, {1'b1, 24'h50_1000}};
    sbcd_decoder #(.NREGS(256)) sbcd_decoder_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce),
        .cmd_valid_i(cmd_valid_i), .cmd_frame_i(cmd_frame_i), .readable_i(rd_map),
        .writable_i(wr_map), .cmd_ready_o(cmd_ready_o), .resp_valid_o(resp_valid_o),
        .resp_frame_o(resp_frame_o), .resp_crc_o(resp_crc_o), .phys_addr_reg_o(phys_o),
        .periodic_mode_enable_o(pm_en), .periodic_collection_mode_o(pm_mode));
    sbcd_master_model sbcd_master_model_i (.clk_i(clk_i), .cmd_ready_i(cmd_ready_o),
        .cmd_valid_o(cmd_valid_i), .cmd_frame_o(cmd_frame_i));
    //////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] crc_of(input logic [31:0] d);
        logic [7:0] c;
        c = SBCD_CRC_SEED;
        for (int i = 39; i >= 0; i--)
            c = {c[6:0], (i >= 8) ? d[i-8] : 1'b0} ^ (c[7] ? SBCD_CRC_POLY : 8'h00);
        return c;
    endfunction
    task automatic give_verdict();
        if (failures == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic do_reset();
        @(negedge clk_i);
        rst_n_i = 1'b0;
        repeat (16) @(negedge clk_i);
        rst_n_i = 1'b1;
        phys = SBCD_PHYS_RST;
        `CHK("ready", 1'b1, cmd_ready_o)
        `CHK("phys", SBCD_PHYS_RST, phys_o)
        `CHK("pm_en", 1'b0, pm_en)
        `CHK("resp_valid", 1'b0, resp_valid_o)
    endtask
    task automatic run(input logic [24:0] r);
        sbcd_frame_s f, e;
        logic        ok, seen;
        logic [7:0]  a;
        f = r[23:0];
        a = f.hi;
        seen = 1'b0;
        ok = (f.cmd == SBCD_CMD_WRITE) ? wr_map[a] : rd_map[a];
        if (r[24] && f.cmd == SBCD_CMD_WRITE && ok) begin
            m[a] = f.lo;
            if (a == SBCD_PHYS_ADDR_RA) phys = f.lo[3:0];
        end
        e = {phys, f.cmd, ok ? m[a + 8'h01] : 8'h00, ok ? m[a] : 8'h00};
        if (f.cmd == SBCD_CMD_PERIODIC) e = {phys, f.cmd, 16'h0000};
        sbcd_master_model_i.send(f, took);
        `CHK("take", 1'b1, took)
        for (int k = 0; k < 60 && !seen; k++) begin
            @(negedge clk_i);
            seen = resp_valid_o === 1'b1;
        end
        `CHK("resp_valid", r[24], seen)
        if (seen) `CHK("resp_frame", e, resp_frame_o)
        if (seen) `CHK("resp_addr", phys, resp_frame_o.frame_dev_addr_field)
        if (seen) `CHK("resp_cmd", f.cmd, resp_frame_o.cmd)
        if (seen) `CHK("resp_crc", crc_of({8'h00, e}), resp_crc_o)
        if (seen) `CHK("phys", phys, phys_o)
        if (!took || (r[24] && !seen)) give_verdict();
    endtask
    //////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    initial begin
        rst_n_i = 1'b0;
        failures = 0;
        ce = 1'b1;
        n_compared = 0;
        phys = SBCD_PHYS_RST;
        for (int i = 0; i < 256; i++) begin
            m[i] = 8'h00;
            rd_map[i] = 8'(i) != 8'h30;
            wr_map[i] = 8'(i) < 8'h80;
        end
        do_reset();
        foreach (ROWS[i]) run(ROWS[i]);
        for (int c = 0; c < 16; c++)
            if (!(c inside {0, 8, 11})) run({1'b0, 4'h5, 4'(c), 16'h0000});
        run({1'b1, 24'h5b_0000});
        `CHK("pm_en", 1'b1, pm_en)
        `CHK("pm_mode", 1'b1, pm_mode)
        ce = 1'b0;
        fork
            run({1'b1, 24'h50_2000});
            begin
                @(negedge clk_i);
                `CHK("ready_ce", 1'b0, cmd_ready_o)
                repeat (7) @(negedge clk_i);
                ce = 1'b1;
                repeat (10) @(negedge clk_i);
                ce = 1'b0;
                repeat (8) @(negedge clk_i);
                ce = 1'b1;
            end
        join
        do_reset();
        run({1'b0, 24'h0b_0000});
        `CHK("pm_en", 1'b1, pm_en)
        give_verdict();
    end
endmodule // tb
